/* File: rtl/sfe_front_end.sv */
// How it works
// - Works in clock modes zero and three.
// - Sample on rising, shift out on falling.
// - Command 3B returns two bits per clock.
// - Dual phase drives both lanes, ignores protect.
// - Deselect during pause resets the interface.
// - Pause starts when clock low and pause falls.
// - Pause ends when clock low and pause rises.
// - Paused: output released, clock and input ignored.
// - Pause never aborts running internal operations.
// - Program per page; erase sector, block, chip.
// - Busy flag blocks all but read commands while set.
// - Write latch required for modifying commands.
// - Set and clear commands drive the latch.
// - Latch clears after operations and reset.
// - Guard bits reject program and erase.
// - Chip erase only with all guards clear.
// - Reserved status bit always reads zero.
// - Lock bit plus low protect refuses status writes.
// - Commands arrive MSB first after select.
// - Modifying commands need whole bytes.
`timescale 1ns/100ps
`default_nettype none
`include "sfe_regs.svh"

module sfe_front_end #(
  parameter int ADDR_W = `SFE_ADDR_W,
  parameter int PAGE_BYTES = `SFE_PAGE_BYTES
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Serial link
  input wire logic sck,
  input wire logic csN,
  input wire logic holdN,
  input wire logic wpN,
  input wire logic laneLowIn,
  output logic laneLowOut,
  output logic laneLowOe,
  output logic soOut,
  output logic soOe,
  // Array read port, sck domain
  output logic [ADDR_W-1:0] rdAddr,
  input wire logic [7:0] rdData,
  // Array modify port, core domain
  output logic reqValid,
  output sfe_pkg::sfe_req_t req,
  input wire logic arrayDone,
  input wire logic [7:0] bufIdx,
  output logic [7:0] bufData,
  // Status view
  output sfe_pkg::sfe_status_t statusWord
);

  localparam int WrsrCyc = (`SFE_WRSR_TIME_NS + `SFE_CLK_NS - 1) / `SFE_CLK_NS;
  localparam logic [7:0] WrsrCnt = 8'(WrsrCyc);

  function automatic logic fOk(input logic [2:0] bits, input logic [2:0] bytes,
                               input logic [2:0] need);
    fOk = (bits == 3'h0) && (bytes >= need);
  endfunction : fOk

  // ********************************************
  // Link side, clocked by sck
  // ********************************************
  logic spiRst;
  logic paused;
  logic fresh_r;
  logic frameTgl_r;
  logic pauseCap_r;
  logic [7:0] shift_r;
  logic [2:0] bitCnt_r;
  logic [2:0] byteCnt_r;
  logic [7:0] opcode_r;
  logic [7:0] wrData_r;
  logic [23:0] addr_r;
  logic [8:0] len_r;
  logic [ADDR_W-1:0] rdAddr_r;
  logic [7:0] pageBuf [PAGE_BYTES];
  logic [7:0] txByte_r;
  logic txOn_r;
  logic dualOn_r;
  logic [7:0] snap_r;
  logic tglS1_r;
  logic tglS2_r;
  logic ack_r;
  logic [2:0] curBit;
  logic [2:0] curByte;
  logic [7:0] inByte;
  logic byteDone;
  logic isDual;
  logic isRead;
  logic isProg;
  logic [2:0] dataStart;
  logic unitDone;
  logic unitLoad;
  logic shiftEn;
  logic [7:0] statusPub_r;
  logic pubTgl_r;

  assign spiRst = csN | ~arst_n;
  assign shiftEn = ~csN & holdN;
  assign curBit = fresh_r ? 3'h0 : bitCnt_r;
  assign curByte = fresh_r ? 3'h0 : byteCnt_r;
  assign inByte = {shift_r[6:0], laneLowIn};
  assign byteDone = (curBit == 3'h7);
  assign isDual = (opcode_r == `SFE_CMD_DUAL);
  assign isProg = (opcode_r == `SFE_CMD_PROG);
  assign isRead = isDual | (opcode_r == `SFE_CMD_READ) | (opcode_r == `SFE_CMD_FAST);
  assign dataStart = (opcode_r == `SFE_CMD_READ) ? 3'h4 : 3'h5;
  assign unitDone = isRead && (curByte >= dataStart) &&
                    (isDual ? (curBit[1:0] == 2'h3) : byteDone);
  assign unitLoad = ~fresh_r && (isRead ?
                    (byteCnt_r >= dataStart) &&
                    (isDual ? (bitCnt_r[1:0] == 2'h0) : (bitCnt_r == 3'h0)) :
                    (opcode_r == `SFE_CMD_RDSR) && (byteCnt_r != 3'h0) &&
                    (bitCnt_r == 3'h0));

  // While sck is high the pause keeps the level seen at the last low phase.
  assign paused = ~csN & (sck ? pauseCap_r : ~holdN);

  always_ff @(posedge sck or posedge spiRst) begin
    if (spiRst) begin
      pauseCap_r <= 1'b0;
    end else begin
      pauseCap_r <= ~holdN;
    end
  end

  always_ff @(posedge sck or posedge spiRst) begin
    if (spiRst) begin
      fresh_r <= 1'b1;
    end else if (holdN) begin
      fresh_r <= 1'b0;
    end
  end

  // Frame fields survive deselect so the core can read them after it.
  // The toggle flips once per clocked frame, so an empty frame cannot replay the last one.
  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= 8'h00;
      bitCnt_r <= 3'h0;
      byteCnt_r <= 3'h0;
      opcode_r <= 8'h00;
      wrData_r <= 8'h00;
      addr_r <= 24'h000000;
      frameTgl_r <= 1'b0;
    end else if (shiftEn) begin
      frameTgl_r <= frameTgl_r ^ fresh_r;
      shift_r <= inByte;
      bitCnt_r <= curBit + 3'h1;
      byteCnt_r <= (byteDone && curByte != 3'h7) ? curByte + 3'h1 : curByte;
      if (byteDone) begin
        unique case (curByte)
          3'h0: opcode_r <= inByte;
          3'h1: begin
            addr_r[23:16] <= inByte;
            wrData_r <= inByte;
          end
          3'h2: addr_r[15:8] <= inByte;
          3'h3: addr_r[7:0] <= inByte;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      len_r <= 9'h000;
    end else if (shiftEn) begin
      if (fresh_r) begin
        len_r <= 9'h000;
      end else if (byteDone && curByte >= 3'h4 && isProg && len_r != 9'(PAGE_BYTES)) begin
        len_r <= len_r + 9'h001;
      end
    end
  end

  // Program data wraps inside the page, as the array does.
  always_ff @(posedge sck) begin
    if (shiftEn && byteDone && curByte >= 3'h4 && isProg) begin
      pageBuf[addr_r[7:0] + len_r[7:0]] <= inByte;
    end
  end

  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      rdAddr_r <= '0;
    end else if (shiftEn) begin
      if (byteDone && curByte == 3'h3) begin
        rdAddr_r <= ADDR_W'({addr_r[23:8], inByte});
      end else if (unitDone) begin
        rdAddr_r <= rdAddr_r + ADDR_W'(1);
      end
    end
  end

  // Status snapshot handshake; a pending update waits for sck edges.
  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      tglS1_r <= 1'b0;
      tglS2_r <= 1'b0;
      ack_r <= 1'b0;
      snap_r <= `SFE_STATUS_RESET;
    end else begin
      tglS1_r <= pubTgl_r;
      tglS2_r <= tglS1_r;
      if (tglS2_r != ack_r) begin
        snap_r <= statusPub_r;
        ack_r <= tglS2_r;
      end
    end
  end

  // A stale count from the last frame is masked until the first rising edge.
  always_ff @(negedge sck or posedge spiRst) begin
    if (spiRst) begin
      txByte_r <= 8'h00;
      txOn_r <= 1'b0;
      dualOn_r <= 1'b0;
    end else if (holdN) begin
      if (unitLoad) begin
        txByte_r <= isRead ? rdData : snap_r;
        txOn_r <= 1'b1;
        dualOn_r <= isDual;
      end else if (dualOn_r) begin
        txByte_r <= {txByte_r[5:0], 2'h0};
      end else begin
        txByte_r <= {txByte_r[6:0], 1'b0};
      end
    end
  end

  assign soOut = txByte_r[7];
  assign laneLowOut = txByte_r[6];
  assign soOe = txOn_r & ~paused;
  assign laneLowOe = txOn_r & dualOn_r & ~paused;
  assign rdAddr = rdAddr_r;

  // ********************************************
  // Core side, clocked by core_clk
  // ********************************************
  logic csS1_r;
  logic csS2_r;
  logic csS3_r;
  logic wpS1_r;
  logic wpS2_r;
  logic ackS1_r;
  logic ackS2_r;
  logic frameSeen_r;
  logic csRise;
  logic exec;
  logic cmdWren;
  logic cmdWrdi;
  logic cmdWrsr;
  logic arrayCmd;
  logic opDone;
  logic areaLocked;
  logic wel_r;
  logic lock_r;
  logic [3:0] guard_r;
  logic [7:0] timer_r;
  logic reqValid_r;
  logic [7:0] bufData_r;
  sfe_pkg::sfe_core_st_t state_r;
  sfe_pkg::sfe_op_t opKind;
  sfe_pkg::sfe_req_t req_r;
  sfe_pkg::sfe_status_t statusW;
  logic [ADDR_W-1:0] reqBase;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      csS1_r <= 1'b1;
      csS2_r <= 1'b1;
      csS3_r <= 1'b1;
      wpS1_r <= 1'b1;
      wpS2_r <= 1'b1;
      ackS1_r <= 1'b0;
      ackS2_r <= 1'b0;
    end else begin
      csS1_r <= csN;
      csS2_r <= csS1_r;
      csS3_r <= csS2_r;
      wpS1_r <= wpN;
      wpS2_r <= wpS1_r;
      ackS1_r <= ack_r;
      ackS2_r <= ackS1_r;
    end
  end

  // Frame fields are quiet once select is high, so reading them here is safe.
  assign csRise = csS2_r & ~csS3_r;
  assign exec = csRise && (state_r == sfe_pkg::ST_IDLE) && (frameTgl_r != frameSeen_r);
  assign cmdWren = exec && opcode_r == `SFE_CMD_SET_WRITE_LATCH_CMD && fOk(bitCnt_r, byteCnt_r, 3'h1);
  assign cmdWrdi = exec && opcode_r == `SFE_CMD_CLEAR_WRITE_LATCH_CMD && fOk(bitCnt_r, byteCnt_r, 3'h1);
  assign cmdWrsr = exec && wel_r && opcode_r == `SFE_CMD_WRSR &&
                   fOk(bitCnt_r, byteCnt_r, 3'h2) && !(lock_r && !wpS2_r);

  // Counts of the last frame stay behind, so a frame without clocks must not run them again.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frameSeen_r <= 1'b0;
    end else if (csRise) begin
      frameSeen_r <= frameTgl_r;
    end
  end

  always_comb begin
    opKind = sfe_pkg::OP_PROG;
    arrayCmd = 1'b0;
    if (exec && wel_r) begin
      unique case (opcode_r)
        `SFE_CMD_PROG: arrayCmd = fOk(bitCnt_r, byteCnt_r, 3'h5) && !areaLocked;
        `SFE_CMD_SECT: begin
          opKind = sfe_pkg::OP_SECT;
          arrayCmd = fOk(bitCnt_r, byteCnt_r, 3'h4) && !areaLocked;
        end
        `SFE_CMD_BLOCK: begin
          opKind = sfe_pkg::OP_BLOCK;
          arrayCmd = fOk(bitCnt_r, byteCnt_r, 3'h4) && !areaLocked;
        end
        `SFE_CMD_CHIP: begin
          opKind = sfe_pkg::OP_CHIP;
          arrayCmd = fOk(bitCnt_r, byteCnt_r, 3'h1) && (guard_r == 4'h0);
        end
        default: ;
      endcase
    end
  end

  sfe_geom #(
    .ADDR_W(ADDR_W)
  ) u_geom (
    .kind(opKind),
    .addr(addr_r[ADDR_W-1:0]),
    .guard(guard_r),
    .base(reqBase),
    .reject(areaLocked)
  );

  // The pause pin never reaches this machine, so running work goes on.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= sfe_pkg::ST_IDLE;
      timer_r <= 8'h00;
    end else begin
      unique case (state_r)
        sfe_pkg::ST_IDLE: begin
          if (cmdWrsr) begin
            state_r <= sfe_pkg::ST_WRSR;
            timer_r <= WrsrCnt;
          end else if (arrayCmd) begin
            state_r <= sfe_pkg::ST_ARRAY;
          end
        end
        sfe_pkg::ST_WRSR: begin
          timer_r <= timer_r - 8'h01;
          if (timer_r == 8'h01) begin
            state_r <= sfe_pkg::ST_IDLE;
          end
        end
        sfe_pkg::ST_ARRAY: begin
          if (arrayDone) begin
            state_r <= sfe_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  assign opDone = (state_r == sfe_pkg::ST_WRSR && timer_r == 8'h01) ||
                  (state_r == sfe_pkg::ST_ARRAY && arrayDone);

  // Set happens only when idle and the end clear only when busy, so they never meet.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wel_r <= 1'b0;
    end else if (cmdWren) begin
      wel_r <= 1'b1;
    end else if (cmdWrdi || opDone) begin
      wel_r <= 1'b0;
    end
  end

  // Guard and lock bits are retained in flops; reset stands in for the factory value.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      guard_r <= 4'h0;
      lock_r <= 1'b0;
    end else if (cmdWrsr) begin
      guard_r <= wrData_r[`SFE_BIT_GUARD_HI:`SFE_BIT_GUARD_LO];
      lock_r <= wrData_r[`SFE_BIT_LOCK];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reqValid_r <= 1'b0;
      req_r <= '0;
      bufData_r <= 8'h00;
    end else begin
      reqValid_r <= arrayCmd;
      bufData_r <= pageBuf[bufIdx];
      if (arrayCmd) begin
        req_r <= '{kind: opKind, addr: reqBase, len: len_r};
      end
    end
  end

  assign statusW = {lock_r, 1'b0, guard_r, wel_r, state_r != sfe_pkg::ST_IDLE};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      statusPub_r <= `SFE_STATUS_RESET;
      pubTgl_r <= 1'b0;
    end else if (ackS2_r == pubTgl_r && statusPub_r != statusW) begin
      statusPub_r <= statusW;
      pubTgl_r <= ~pubTgl_r;
    end
  end

  assign reqValid = reqValid_r;
  assign req = req_r;
  assign bufData = bufData_r;
  assign statusWord = statusW;

  // ********************************************
  // Checks
  // ********************************************
  property p_wel_set;
    @(posedge core_clk) disable iff (!arst_n)
      exec && opcode_r == `SFE_CMD_SET_WRITE_LATCH_CMD && bitCnt_r == 3'h0 && byteCnt_r != 3'h0
      |=> wel_r;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");

  property p_wel_end;
    @(posedge core_clk) disable iff (!arst_n)
      (state_r != sfe_pkg::ST_IDLE) ##1 (state_r == sfe_pkg::ST_IDLE) |-> !wel_r;
  endproperty
  a_wel_end: assert property (p_wel_end) else $error("latch kept after op");

  property p_req_wel;
    @(posedge core_clk) disable iff (!arst_n)
      reqValid_r |-> $past(wel_r) && state_r == sfe_pkg::ST_ARRAY;
  endproperty
  a_req_wel: assert property (p_req_wel) else $error("op without latch");

  property p_busy_ignore;
    @(posedge core_clk) disable iff (!arst_n)
      csRise && state_r != sfe_pkg::ST_IDLE |=> !reqValid_r && $stable(guard_r);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("busy took cmd");

  property p_wrsr_len;
    @(posedge core_clk) disable iff (!arst_n)
      $rose(state_r == sfe_pkg::ST_WRSR) |-> ##[1:WrsrCyc] state_r == sfe_pkg::ST_IDLE;
  endproperty
  a_wrsr_len: assert property (p_wrsr_len) else $error("status write hung");

  property p_rsvd;
    @(posedge core_clk) disable iff (!arst_n)
      statusPub_r[`SFE_BIT_RSVD] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  property p_chip_guard;
    @(posedge core_clk) disable iff (!arst_n)
      reqValid_r && req_r.kind == sfe_pkg::OP_CHIP |-> $past(guard_r) == 4'h0;
  endproperty
  a_chip_guard: assert property (p_chip_guard) else $error("chip erase guarded");

  property p_lock;
    @(posedge core_clk) disable iff (!arst_n)
      exec && opcode_r == `SFE_CMD_WRSR && lock_r && !wpS2_r
      |=> state_r == sfe_pkg::ST_IDLE && $stable(guard_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked status written");

  property p_mod8;
    @(posedge core_clk) disable iff (!arst_n)
      csRise && bitCnt_r != 3'h0 |=> !reqValid_r && state_r != sfe_pkg::ST_WRSR;
  endproperty
  a_mod8: assert property (p_mod8) else $error("partial byte ran");

  property p_pause_hiz;
    @(posedge sck) disable iff (csN || !arst_n)
      !holdN |-> !soOe && !laneLowOe;
  endproperty
  a_pause_hiz: assert property (p_pause_hiz) else $error("driven while paused");

  property p_bit_step;
    @(posedge sck) disable iff (csN || !arst_n)
      holdN && !fresh_r |=> bitCnt_r == $past(bitCnt_r) + 3'h1;
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("bit count slipped");

endmodule : sfe_front_end
`default_nettype wire

/* File: pkg/sfe_regs.svh */
`ifndef SFE_REGS_SVH
`define SFE_REGS_SVH

// ********************************************
// Status word bit positions and reset value
// ********************************************
`define SFE_BIT_BUSY 0
`define SFE_BIT_WEL 1
`define SFE_BIT_GUARD_LO 2
`define SFE_BIT_GUARD_HI 5
`define SFE_BIT_RSVD 6
`define SFE_BIT_LOCK 7
`define SFE_STATUS_RESET 8'h00

// ********************************************
// Command codes
// ********************************************
`define SFE_CMD_WRSR 8'h01
`define SFE_CMD_PROG 8'h02
`define SFE_CMD_READ 8'h03
`define SFE_CMD_CLEAR_WRITE_LATCH_CMD 8'h04
`define SFE_CMD_RDSR 8'h05
`define SFE_CMD_SET_WRITE_LATCH_CMD 8'h06
`define SFE_CMD_FAST 8'h0B
`define SFE_CMD_DUAL 8'h3B
`define SFE_CMD_SECT 8'h20
`define SFE_CMD_BLOCK 8'hD8
`define SFE_CMD_CHIP 8'hC7

// ********************************************
// Array geometry
// ********************************************
`define SFE_ADDR_W 19
`define SFE_PAGE_BYTES 256
`define SFE_PAGE_LSB 8
`define SFE_SECT_LSB 12
`define SFE_BLOCK_LSB 16

// ********************************************
// Timing
// ********************************************
`define SFE_CLK_NS 10
`define SFE_WRSR_TIME_NS 200

`endif

/* File: pkg/sfe_pkg.sv */
package sfe_pkg;

  typedef enum logic [1:0] {
    OP_PROG,
    OP_SECT,
    OP_BLOCK,
    OP_CHIP
  } sfe_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRSR,
    ST_ARRAY
  } sfe_core_st_t;

  typedef struct packed {
    logic statusLockBit;
    logic reservedBit;
    logic [3:0] areaGuard;
    logic writeEnableLatch;
    logic busyFlag;
  } sfe_status_t;

  typedef struct packed {
    sfe_op_t kind;
    logic [18:0] addr;
    logic [8:0] len;
  } sfe_req_t;

endpackage : sfe_pkg

/* File: rtl/sfe_geom.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sfe_regs.svh"

module sfe_geom #(
  parameter int ADDR_W = `SFE_ADDR_W
) (
  // Request
  input wire sfe_pkg::sfe_op_t kind,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [3:0] guard,
  // Decoded
  output logic [ADDR_W-1:0] base,
  output logic reject
);

  // Erase bases snap to their unit; a page is never an erase unit.
  always_comb begin
    base = addr;
    unique case (kind)
      sfe_pkg::OP_PROG: base = addr;
      sfe_pkg::OP_SECT: base = {addr[ADDR_W-1:`SFE_SECT_LSB], {`SFE_SECT_LSB{1'b0}}};
      sfe_pkg::OP_BLOCK: base = {addr[ADDR_W-1:`SFE_BLOCK_LSB], {`SFE_BLOCK_LSB{1'b0}}};
      sfe_pkg::OP_CHIP: base = '0;
    endcase
  end

  // Any guard bit set locks the whole array; finer area decoding is not modelled.
  assign reject = |guard;

endmodule : sfe_geom
`default_nettype wire

/* File: verification/sfe_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module sfe_host_model (
  // Link driven by the host
  output logic sck,
  output logic csN,
  output logic holdN,
  output logic laneLowIn,
  // Link driven by the device
  input wire logic soOut,
  input wire logic soOe,
  input wire logic laneLowOut,
  input wire logic laneLowOe
);
  // ****************************************
  // Frame tasks, link clock of 32 ns
  // ****************************************
  logic modeHigh;
  logic soLine;

  initial begin
    modeHigh = 1'h0;
    sck = 1'h0;
    csN = 1'h1;
    holdN = 1'h1;
    laneLowIn = 1'h0;
    soLine = 1'h0;
  end

  task automatic select(input logic m3);
    modeHigh = m3;
    sck = m3;
    holdN = 1'h1;
    #20;
    csN = 1'h0;
    #16;
  endtask : select

  task automatic shift_bits(input logic [47:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      sck = 1'h0;
      laneLowIn = d[47 - i];
      #16;
      sck = 1'h1;
      #16;
    end
  endtask : shift_bits

  // A released output reads back as the inverse of its last level, so a
  // missing driver can never pass for data.
  task automatic read_byte(output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      sck = 1'h0;
      #16;
      sck = 1'h1;
      soLine = soOe ? soOut : ~soLine;
      rx = {rx[6:0], soLine};
      #16;
    end
  endtask : read_byte

  task automatic read_dual(output logic [7:0] rx, output logic both);
    both = 1'h1;
    for (int i = 0; i < 4; i++) begin
      sck = 1'h0;
      #16;
      sck = 1'h1;
      rx = {rx[5:0], soOut, laneLowOut};
      both = both & soOe & laneLowOe;
      #16;
    end
  endtask : read_dual

  task automatic set_pause(input logic level);
    sck = 1'h0;
    #8;
    holdN = level;
    #8;
  endtask : set_pause

  task automatic deselect();
    if (!modeHigh) begin
      sck = 1'h0;
    end
    #16;
    csN = 1'h1;
    laneLowIn = ~laneLowIn;
    #100;
  endtask : deselect
endmodule : sfe_host_model

`default_nettype wire

/* File: verification/sfe_front_end_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module sfe_front_end_bench;
  // ****************************************
  // Hookup
  // ****************************************
  typedef struct packed {
    logic m3;
    logic [7:0] op;
    logic [7:0] nBits;
    logic [7:0] exp;
  } sfe_row_t;

  logic core_clk, arst_n, sck, csN, holdN, wpN, laneLowIn, laneLowOut, laneLowOe;
  logic soOut, soOe, reqValid, arrayDone, both;
  logic [18:0] rdAddr;
  logic [7:0] rdData, bufIdx, bufData, got;
  sfe_pkg::sfe_req_t req, lastReq;
  sfe_pkg::sfe_status_t statusWord;
  int numErrors, nTests, reqCount;
  sfe_row_t rows [8];

  assign rdData = rdAddr[7:0] ^ 8'h5A;

  sfe_front_end sfe_front_end_i (
    .core_clk(core_clk), .arst_n(arst_n), .sck(sck), .csN(csN), .holdN(holdN),
    .wpN(wpN), .laneLowIn(laneLowIn), .laneLowOut(laneLowOut), .laneLowOe(laneLowOe),
    .soOut(soOut), .soOe(soOe), .rdAddr(rdAddr), .rdData(rdData), .reqValid(reqValid),
    .req(req), .arrayDone(arrayDone), .bufIdx(bufIdx), .bufData(bufData),
    .statusWord(statusWord)
  );

  sfe_host_model sfe_host_model_i (
    .sck(sck), .csN(csN), .holdN(holdN), .laneLowIn(laneLowIn), .soOut(soOut),
    .soOe(soOe), .laneLowOut(laneLowOut), .laneLowOe(laneLowOe)
  );

  initial core_clk = 1'h0;
  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (reqValid === 1'h1) begin
      reqCount = reqCount + 1;
      lastReq = req;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check8

  task automatic check_req(input string what, input logic [20:0] exp);
    nTests++;
    if ({lastReq.kind, lastReq.addr} !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, {lastReq.kind, lastReq.addr});
    end
  endtask : check_req

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cycles

  task automatic frame(input logic m3, input logic [47:0] d, input int n);
    sfe_host_model_i.select(m3);
    sfe_host_model_i.shift_bits(d, n);
    sfe_host_model_i.deselect();
    cycles(4);
  endtask : frame

  task automatic set_write_latch_cmd();
    frame(1'h0, {8'h06, 40'h0}, 8);
  endtask : set_write_latch_cmd

  task automatic wrsr(input logic [7:0] v);
    frame(1'h0, {8'h01, v, 32'h0}, 16);
  endtask : wrsr

  task automatic wait_idle();
    for (int i = 0; i < 100 && statusWord.busyFlag !== 1'h0; i++) begin
      cycles(1);
    end
    check8("busy cleared", 8'h00, {7'h0, statusWord.busyFlag});
    cycles(2);
  endtask : wait_idle

  task automatic done_pulse();
    cycles(1);
    arrayDone = statusWord.busyFlag;
    cycles(1);
    arrayDone = 1'h0;
    cycles(4);
  endtask : done_pulse

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #300000;
    numErrors++;
    complete_run();
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    rows = '{'{1'h0, 8'h06, 8'h08, 8'h02}, '{1'h0, 8'h04, 8'h08, 8'h00},
             '{1'h1, 8'h06, 8'h08, 8'h02}, '{1'h1, 8'h04, 8'h08, 8'h00},
             '{1'h0, 8'h06, 8'h07, 8'h00}, '{1'h1, 8'h06, 8'h09, 8'h00},
             '{1'h0, 8'h06, 8'h10, 8'h02}, '{1'h1, 8'h04, 8'h08, 8'h00}};
    numErrors = 0;
    nTests = 0;
    reqCount = 0;
    arst_n = 1'h0;
    wpN = 1'h1;
    bufIdx = 8'h00;
    arrayDone = 1'h0;
    repeat (6) @(posedge core_clk);
    #1;
    arst_n = 1'h1;
    cycles(4);
    check8("reset status", 8'h00, statusWord);
    check8("reset drivers", 8'h00, {5'h00, soOe, laneLowOe, reqValid});
    foreach (rows[k]) begin
      frame(rows[k].m3, {rows[k].op, 40'h0}, int'(rows[k].nBits));
      check8("status word", rows[k].exp, statusWord);
      sfe_host_model_i.select(rows[k].m3);
      sfe_host_model_i.shift_bits({8'h05, 40'h0}, 8);
      sfe_host_model_i.read_byte(got);
      sfe_host_model_i.deselect();
      check8("status on link", rows[k].exp, got);
    end
    set_write_latch_cmd();
    wrsr(8'h04);
    check8("status write busy", 8'h01, {7'h0, statusWord.busyFlag});
    wait_idle();
    check8("guard written", 8'h04, statusWord);
    set_write_latch_cmd();
    frame(1'h0, {8'hC7, 40'h0}, 8);
    frame(1'h0, {8'h02, 24'h000100, 8'hA5, 8'h00}, 40);
    check8("guarded requests", 8'h00, 8'(reqCount));
    set_write_latch_cmd();
    wrsr(8'hFC);
    wait_idle();
    check8("lock written", 8'hBC, statusWord);
    cycles(1);
    wpN = ~statusWord.statusLockBit;
    set_write_latch_cmd();
    wrsr(8'h00);
    check8("locked status", 8'hBE, statusWord);
    cycles(1);
    wpN = 1'h1;
    sfe_host_model_i.select(1'h0);
    sfe_host_model_i.deselect();
    cycles(4);
    check8("empty frame", 8'hBE, statusWord);
    wrsr(8'h00);
    wait_idle();
    check8("unlocked status", 8'h00, statusWord);
    frame(1'h0, {8'h02, 24'h012345, 8'hA5, 8'h5A}, 48);
    check8("unlatched program", 8'h00, 8'(reqCount));
    set_write_latch_cmd();
    frame(1'h0, {8'h02, 24'h012345, 8'hA5, 8'h5A}, 48);
    check8("program count", 8'h01, 8'(reqCount));
    check_req("program request", {sfe_pkg::OP_PROG, 19'h12345});
    check8("program length", 8'h02, lastReq.len[7:0]);
    for (int i = 0; i < 2; i++) begin
      bufIdx = 8'h45 + 8'(i);
      cycles(2);
      check8("page byte", (i == 0) ? 8'hA5 : 8'h5A, bufData);
    end
    wrsr(8'h3C);
    sfe_host_model_i.select(1'h0);
    sfe_host_model_i.set_pause(1'h0);
    sfe_host_model_i.deselect();
    check8("busy kept", 8'h03, statusWord);
    done_pulse();
    check8("after program", 8'h00, statusWord);
    set_write_latch_cmd();
    frame(1'h0, {8'h20, 24'h012345, 16'h0}, 32);
    check_req("sector request", {sfe_pkg::OP_SECT, 19'h12000});
    done_pulse();
    check8("after erase", 8'h00, statusWord);
    set_write_latch_cmd();
    frame(1'h0, {8'hC7, 40'h0}, 8);
    check_req("chip request", {sfe_pkg::OP_CHIP, 19'h00000});
    done_pulse();
    sfe_host_model_i.select(1'h1);
    sfe_host_model_i.shift_bits({8'h03, 24'h000010, 16'h0}, 32);
    sfe_host_model_i.read_byte(got);
    check8("read byte", 8'h4A, got);
    sfe_host_model_i.read_byte(got);
    check8("next read byte", 8'h4B, got);
    sfe_host_model_i.deselect();
    cycles(1);
    wpN = 1'h0;
    sfe_host_model_i.select(1'h0);
    sfe_host_model_i.shift_bits({8'h3B, 24'h000010, 16'h0}, 40);
    sfe_host_model_i.read_dual(got, both);
    check8("dual byte", 8'h4A, got);
    check8("dual lanes on", 8'h01, {7'h0, both});
    sfe_host_model_i.deselect();
    check8("lanes released", 8'h00, {6'h0, soOe, laneLowOe});
    cycles(1);
    wpN = 1'h1;
    set_write_latch_cmd();
    sfe_host_model_i.select(1'h0);
    sfe_host_model_i.shift_bits({8'h05, 40'h0}, 8);
    sfe_host_model_i.set_pause(1'h0);
    sfe_host_model_i.shift_bits(48'hFFFFFFFFFFFF, 4);
    check8("paused output", 8'h00, {7'h0, soOe});
    sfe_host_model_i.set_pause(1'h1);
    check8("resumed output", 8'h01, {7'h0, soOe});
    sfe_host_model_i.read_byte(got);
    check8("byte after pause", 8'h02, got);
    sfe_host_model_i.set_pause(1'h0);
    sfe_host_model_i.deselect();
    check8("deselected in pause", 8'h00, {7'h0, soOe});
    frame(1'h0, {8'h04, 40'h0}, 8);
    check8("restart after pause", 8'h00, statusWord);
    complete_run();
  end
endmodule : sfe_front_end_bench

`default_nettype wire
